// >>> watchdog_reset_irq_timer_test.sv
`timescale 1ns/1ps
`default_nettype none
module watchdog_reset_irq_timer_test;
    localparam int T = 10;
    logic        clk, rst_n, io_wr, sys_reset, irq11, irq15, led;
    logic [15:0] io_addr;
    logic [7:0]  io_data, rnd;
    int          bad_count = 0, n_compared = 0, cyc = 0, t0 = 0;
    int          tbl [8] = '{3, 9, 15, 22, 28, 34, 40, 46};
    wdt_top #(.TICK_CYCLES(T), .BLINK_CYCLES(3)) u_wdt_top (.clk(clk), .rst_n(rst_n),
        .io_wr(io_wr), .io_addr(io_addr), .io_data(io_data), .sys_reset(sys_reset),
        .irq11(irq11), .irq15(irq15), .led(led));
    wdt_host u_wdt_host (.clk(clk), .io_wr(io_wr), .io_addr(io_addr), .io_data(io_data));
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            bad_count = bad_count + 1;
            finish_test();
        end
    end
    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction
    function automatic logic [2:0] act(input logic [7:0] c);
        return (c[5:3] == 3'h4) ? 3'h4 : (c[5:3] == 3'h7) ? 3'h2 : 3'h1;
    endfunction
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask
    task automatic finish_test();
        $display("compared %0d, mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic arm(input logic [7:0] c);
        u_wdt_host.put(16'h0076, c);
        t0 = cyc;
        check({irq11, irq15}, 2'h0);
    endtask
    // The model expects the action of the code group after the whole-second period.
    task automatic expire(input logic [7:0] c);
        while (!(sys_reset | irq11 | irq15) && cyc - t0 < 600)
            @(negedge clk);
        check({sys_reset, irq11, irq15}, act(c));
        check((cyc - t0) / T, tbl[c[2:0]]);
        u_wdt_host.put(16'h0076, 8'h00);
        repeat (100) @(negedge clk);
        check({sys_reset, irq11, irq15, led}, 4'h0);
    endtask
    initial begin
        rst_n = 1'b0;
        rnd   = 8'd77;
        repeat (10) @(negedge clk);
        rst_n = 1'b1;
        repeat (40) @(negedge clk);
        check({sys_reset, irq11, irq15, led}, 4'h0);
        foreach (tbl[f]) begin
            for (int g = 0; g < 3; g++) begin
                arm(8'h20 + 8'((g == 1) ? 24 : g * 8) + 8'(f));
                expire(8'h20 + 8'((g == 1) ? 24 : g * 8) + 8'(f));
            end
        end
        repeat (4) begin
            rnd = lfsr(rnd);
            arm(8'h21);
            repeat (rnd[5:0]) @(negedge clk);
        end
        arm(8'h21);
        repeat (40) @(negedge clk);
        while (rnd == 8'h00 || rnd[7:3] inside {5'h04, 5'h06, 5'h07})
            rnd = lfsr(rnd);
        u_wdt_host.put(16'h0077, 8'h20);
        u_wdt_host.put(16'h0076, rnd);
        expire(8'h21);
        arm(8'h27);
        repeat (20) @(negedge clk);
        arm(8'h30);
        expire(8'h30);
        arm(8'h3f);
        repeat (30) @(negedge clk);
        u_wdt_host.put(16'h0076, 8'h00);
        repeat (600) @(negedge clk);
        check({sys_reset, irq11, irq15, led}, 4'h0);
        finish_test();
    end
endmodule // watchdog_reset_irq_timer_test
`default_nettype wire

// >>> wdt_chk.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------------
// Port-level checks of the watchdog.
// ----------------------------------------------------------------------
module wdt_chk #(
    parameter int TICK_CYCLES  = 10,
    parameter int BLINK_CYCLES = 3
) (
    input wire logic        clk,
    input wire logic        rst_n,
    input wire logic        io_wr,
    input wire logic [15:0] io_addr,
    input wire logic [7:0]  io_data,
    input wire logic        sys_reset,
    input wire logic        irq11,
    input wire logic        irq15,
    input wire logic        led
);
    logic       wr_p, ok, acc, hit;
    logic [4:0] grp_r;
    int         cnt_r, per_r;
    assign wr_p = io_wr && io_addr == 16'h0076;
    assign ok   = io_data[7:3] inside {5'h04, 5'h06, 5'h07};
    assign acc  = wr_p && (ok || io_data == 8'h00);
    assign hit  = sys_reset | irq11 | irq15;
    // Cycles since the last accepted write; a zero write leaves group 0 so no action may follow.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_r <= 0;
            per_r <= 0;
            grp_r <= 5'h00;
        end else if (acc) begin
            cnt_r <= 0;
            per_r <= wdt_pkg::PERIOD_SEC[io_data[2:0]] * TICK_CYCLES;
            grp_r <= io_data[7:3];
        end else begin
            cnt_r <= cnt_r + 1;
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    property p_when; $rose(hit) |-> cnt_r >= per_r - 1 && cnt_r <= per_r + 4; endproperty
    a_when: assert property (p_when)
        else $error("expiry at wrong time");
    property p_rgrp; $rose(sys_reset) |-> grp_r == wdt_pkg::GROUP_RESET; endproperty
    a_rgrp: assert property (p_rgrp)
        else $error("reset from wrong group");
    property p_i11; $rose(irq11) |-> grp_r == wdt_pkg::GROUP_IRQ11 && !irq15; endproperty
    a_i11: assert property (p_i11)
        else $error("irq11 from wrong group");
    property p_i15; $rose(irq15) |-> grp_r == wdt_pkg::GROUP_IRQ15 && !sys_reset; endproperty
    a_i15: assert property (p_i15)
        else $error("irq15 from wrong group");
    property p_pulse; $rose(sys_reset) |-> sys_reset [*8]; endproperty
    a_pulse: assert property (p_pulse)
        else $error("reset pulse too short");
    property p_hold; (irq11 || irq15) && !acc |=> $stable({irq11, irq15}); endproperty
    a_hold: assert property (p_hold)
        else $error("irq dropped without write");
    property p_dark; wr_p && io_data == 8'h00 |-> ##2 (!led) [*8]; endproperty
    a_dark: assert property (p_dark)
        else $error("led lit while disarmed");
    property p_blink; wr_p && ok |-> ##[1:8] led != $past(led); endproperty
    a_blink: assert property (p_blink)
        else $error("led not blinking");
endmodule // wdt_chk
bind wdt_top wdt_chk #(.TICK_CYCLES(TICK_CYCLES), .BLINK_CYCLES(BLINK_CYCLES)) u_chk (
    .clk(clk), .rst_n(rst_n), .io_wr(io_wr), .io_addr(io_addr), .io_data(io_data),
    .sys_reset(sys_reset), .irq11(irq11), .irq15(irq15), .led(led));
`default_nettype wire

// >>> wdt_host.sv
`timescale 1ns/1ps
`default_nettype none
module wdt_host (
    input  wire logic        clk,
    output var  logic        io_wr,
    output var  logic [15:0] io_addr,
    output var  logic [7:0]  io_data
);
    initial begin
        io_wr   = 1'b0;
        io_addr = 16'h0000;
        io_data = 8'h00;
    end
    // Address and data are inverted once the strobe drops, so stale values never look valid.
    task automatic put(input logic [15:0] a, input logic [7:0] d);
        @(negedge clk);
        io_wr   <= 1'b1;
        io_addr <= a;
        io_data <= d;
        @(negedge clk);
        io_wr   <= 1'b0;
        io_addr <= ~a;
        io_data <= ~d;
    endtask
endmodule // wdt_host
`default_nettype wire

// >>> wdt_pkg.sv
package wdt_pkg;

    // ------------------------------------------------------------------
    // Port and codes
    // ------------------------------------------------------------------
    localparam logic [15:0] WATCHDOG_PORT_ADDRESS = 16'h0076;
    localparam logic [7:0]  CODE_DISABLE          = 8'h00;
    localparam logic [4:0]  GROUP_RESET           = 5'h04;
    localparam logic [4:0]  GROUP_IRQ15           = 5'h06;
    localparam logic [4:0]  GROUP_IRQ11           = 5'h07;
    localparam int          FACTOR_LSB            = 0;
    localparam int          FACTOR_W              = 3;
    localparam int          GROUP_LSB             = 3;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int CLK_HZ          = 10_000_000;
    localparam int TICK_MS         = 1000;
    localparam int TICK_CYCLES     = CLK_HZ / 1000 * TICK_MS;
    localparam int RESET_PULSE_US  = 10;
    localparam int RESET_PULSE_CYC = RESET_PULSE_US * (CLK_HZ / 1_000_000);
    localparam int BLINK_MS        = 500;
    localparam int BLINK_CYCLES    = CLK_HZ / 1000 * BLINK_MS;

    // Time-out in seconds for factors one to eight.
    localparam logic [5:0] PERIOD_SEC [8] = '{6'd3, 6'd9, 6'd15, 6'd22,
                                             6'd28, 6'd34, 6'd40, 6'd46};

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {WDT_ACT_RESET, WDT_ACT_IRQ11, WDT_ACT_IRQ15} wdt_action_t;

    typedef struct packed {
        logic        wr;
        logic [15:0] addr;
        logic [7:0]  data;
    } wdt_io_t;

    typedef struct packed {
        logic sys_reset;
        logic irq11;
        logic irq15;
        logic led;
    } wdt_out_t;

endpackage

// >>> wdt_tick.sv
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------------
// Free-running divider giving a one-cycle pulse every period.
// ----------------------------------------------------------------------
module wdt_tick #(
    parameter int PERIOD = 10_000_000
) (
    // Clock and reset
    input  wire logic clk,
    input  wire logic rst_n,
    // Restart and pulse
    input  wire logic restart,
    output var  logic tick
);

    logic [31:0] cnt_r;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_r <= 32'h0;
            tick  <= 1'b0;
        end else if (restart || cnt_r == 32'(PERIOD - 1)) begin
            cnt_r <= 32'h0;
            tick  <= !restart;
        end else begin
            cnt_r <= cnt_r + 32'h1;
            tick  <= 1'b0;
        end
    end

endmodule // wdt_tick

`default_nettype wire

// >>> wdt_top.sv
//Function
//- Valid-code write to port 76h arms timer.
//- New valid code changes the period.
//- Writing zero disables; no further action.
//- Code group selects reset, IRQ11, IRQ15.
//- Factor one to eight, eight codes.
//- Periods 3,9,15,22,28,34,40,46 seconds.
//- IRQ15 group asserts IRQ15 on expiry.
//- 24h and 34h give 28 seconds.
//- Disabled after reset until valid-code write.
//- Retrigger reloads the full period.
//- Reset group expiry emits system reset pulse.
//- LED blinks while armed, steady otherwise.
`timescale 1ns/1ps
`default_nettype none

module wdt_top #(
    parameter int TICK_CYCLES = wdt_pkg::TICK_CYCLES,
    parameter int BLINK_CYCLES = wdt_pkg::BLINK_CYCLES
) (
    // Clock and reset
    input  wire logic            clk,
    input  wire logic            rst_n,
    // Host I/O write port
    input  wire logic            io_wr,
    input  wire logic [15:0]     io_addr,
    input  wire logic [7:0]      io_data,
    // Time-out actions and indicator
    output var  logic            sys_reset,
    output var  logic            irq11,
    output var  logic            irq15,
    output var  logic            led
);

    // ------------------------------------------------------------------
    // Code decode
    // ------------------------------------------------------------------
    function automatic logic code_valid(input logic [7:0] c);
        logic [4:0] g;
        g = c[7:wdt_pkg::GROUP_LSB];
        code_valid = (g == wdt_pkg::GROUP_RESET) || (g == wdt_pkg::GROUP_IRQ11) ||
                     (g == wdt_pkg::GROUP_IRQ15);
    endfunction

    function automatic wdt_pkg::wdt_action_t code_action(input logic [7:0] c);
        logic [4:0] g;
        g = c[7:wdt_pkg::GROUP_LSB];
        if (g == wdt_pkg::GROUP_IRQ11) begin
            code_action = wdt_pkg::WDT_ACT_IRQ11;
        end else if (g == wdt_pkg::GROUP_IRQ15) begin
            code_action = wdt_pkg::WDT_ACT_IRQ15;
        end else begin
            code_action = wdt_pkg::WDT_ACT_RESET;
        end
    endfunction

    wdt_pkg::wdt_io_t io;
    assign io = '{wr: io_wr, addr: io_addr, data: io_data};

    logic hit;
    logic wr_off;
    logic wr_arm;
    assign hit    = io.wr && io.addr == wdt_pkg::WATCHDOG_PORT_ADDRESS;
    assign wr_off = hit && io.data == wdt_pkg::CODE_DISABLE;
    assign wr_arm = hit && code_valid(io.data);

    // ------------------------------------------------------------------
    // Seconds timebase
    // ------------------------------------------------------------------
    // Restarted on each arm so that the first second is a full one.
    logic sec_tick;
    wdt_tick #(.PERIOD(TICK_CYCLES)) u_sec (
        .clk     (clk),
        .rst_n   (rst_n),
        .restart (wr_arm),
        .tick    (sec_tick)
    );

    // ------------------------------------------------------------------
    // Arming state and countdown
    // ------------------------------------------------------------------
    logic                 armed_r;
    logic [5:0]           count_r;
    wdt_pkg::wdt_action_t action_r;
    logic                 expire;

    // An arming or zero write in the expiry cycle wins, so a late disable still prevents any action.
    assign expire = armed_r && !wr_arm && !wr_off && sec_tick && count_r == 6'h01;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            armed_r <= 1'b0;
        end else if (wr_off || expire) begin
            armed_r <= 1'b0;
        end else if (wr_arm) begin
            armed_r <= 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            count_r  <= 6'h00;
            action_r <= wdt_pkg::WDT_ACT_RESET;
        end else if (wr_arm) begin
            // Reload the full period from the new factor.
            count_r  <= wdt_pkg::PERIOD_SEC[io.data[wdt_pkg::FACTOR_W-1:0]];
            action_r <= code_action(io.data);
        end else if (armed_r && sec_tick) begin
            count_r <= count_r - 6'h01;
        end
    end

    // ------------------------------------------------------------------
    // Time-out actions
    // ------------------------------------------------------------------
    logic [15:0] rst_cnt_r;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_cnt_r <= 16'h0;
            sys_reset <= 1'b0;
        end else if (expire && action_r == wdt_pkg::WDT_ACT_RESET) begin
            rst_cnt_r <= 16'(wdt_pkg::RESET_PULSE_CYC - 1);
            sys_reset <= 1'b1;
        end else if (rst_cnt_r != 16'h0) begin
            rst_cnt_r <= rst_cnt_r - 16'h1;
        end else begin
            sys_reset <= 1'b0;
        end
    end

    // Interrupt lines hold their level until the host writes zero or a valid code to the port.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            irq11 <= 1'b0;
            irq15 <= 1'b0;
        end else if (expire) begin
            irq11 <= action_r == wdt_pkg::WDT_ACT_IRQ11;
            irq15 <= action_r == wdt_pkg::WDT_ACT_IRQ15;
        end else if (hit && (wr_off || wr_arm)) begin
            irq11 <= 1'b0;
            irq15 <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Front-panel indicator
    // ------------------------------------------------------------------
    logic [31:0] blink_r;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            blink_r <= 32'h0;
            led     <= 1'b0;
        end else if (!armed_r) begin
            blink_r <= 32'h0;
            led     <= 1'b0;
        end else if (blink_r == 32'(BLINK_CYCLES - 1)) begin
            blink_r <= 32'h0;
            led     <= !led;
        end else begin
            blink_r <= blink_r + 32'h1;
        end
    end

endmodule // wdt_top

`default_nettype wire
